// *** design/clock_source_defs.svh ***
// Register offsets, field positions, reset values and synchronizer stage count
`ifndef CLOCK_SOURCE_DEFS_SVH
`define CLOCK_SOURCE_DEFS_SVH

`define OFFSET_SOURCE_CONTROL  12'h000
`define OFFSET_DIVIDER_CONTROL 12'h004
`define OFFSET_COARSE_TRIM     12'h008
`define OFFSET_STATUS_TRIM     12'h00c

`define FIELD_SOURCE_SELECT    6
`define FIELD_STOP_KEEPALIVE   0
`define FIELD_DIVIDER_HI       7
`define FIELD_DIVIDER_LO       6
`define FIELD_LOOP_POWER_DOWN  3
`define FIELD_ACTIVE_SOURCE    2
`define FIELD_FINE_ADJUST      0

`define RESET_DIVIDER_SELECT   2'h1
`define RESET_COARSE_TRIM      8'h80
`define SYNC_STAGES            2

`endif

// *** design/clock_source_pkg.sv ***
// Types shared by the clock source control logic
package clock_source_pkg;

    typedef enum logic [2:0] {
        MODE_LOOP_ENGAGED   = 3'b000,
        MODE_LOOP_BYPASSED  = 3'b001,
        MODE_BYPASSED_LP    = 3'b010,
        MODE_STOP           = 3'b011
    } clock_mode_type;

endpackage

// *** design/internal_clock_source_ctrl.sv ***
// Clock source control: mode machine, dividers, APB register file
`timescale 1ns/1ps
`include "clock_source_defs.svh"

module internal_clock_source_ctrl #(
    parameter int LOOP_MULTIPLIER = 512,
    parameter int SYNC_DEPTH      = `SYNC_STAGES
) (
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Clock inputs from the analog cores
    input  wire logic        LOOP_CLK,
    input  wire logic        REFERENCE_CLK,
    // Device stop request
    input  wire logic        STOP_REQUEST,
    // Controls to the analog cores
    output logic             LOOP_ENABLE,
    output logic             REFERENCE_ENABLE,
    output logic      [15:0] LOOP_MULTIPLY,
    output logic      [8:0]  REFERENCE_TRIM,
    // Clock outputs and current mode
    output logic             SYSTEM_CLOCK_OUTPUT,
    output logic             BUS_CLOCK,
    output logic      [2:0]  MODE
);

    initial begin
        if (SYNC_DEPTH < 2 || LOOP_MULTIPLIER < 1 || LOOP_MULTIPLIER > 65535)
            $error("Unsupported parameter value");
    end

    clock_source_pkg::clock_mode_type mode_reg, mode_next;
    clock_source_pkg::clock_mode_type resume_reg, resume_next;
    logic       source_select_reg, source_select_next;
    logic       keepalive_reg, keepalive_next;
    logic [1:0] divider_reg, divider_next;
    logic       power_down_reg, power_down_next;
    logic [7:0] coarse_reg, coarse_next;
    logic       fine_reg, fine_next;
    logic [SYNC_DEPTH-1:0] sync_reg, sync_next;
    logic       active_reg, active_next;
    logic [3:0] sample_count_reg, sample_count_next;
    logic [2:0] div_count_reg, div_count_next;
    logic       out_reg, out_next;
    logic       bus_reg, bus_next;
    logic       loop_sample_reg, ref_sample_reg;
    logic       src_prev_reg, src_prev_next;
    logic       src_now;
    logic       src_edge;
    logic       write_access;
    logic       read_access;
    logic       mapped;

    // Register decode shared by the write path and the error response
    function automatic logic is_mapped(input logic [11:0] addr);
        is_mapped = (addr == `OFFSET_SOURCE_CONTROL)
                 || (addr == `OFFSET_DIVIDER_CONTROL)
                 || (addr == `OFFSET_COARSE_TRIM)
                 || (addr == `OFFSET_STATUS_TRIM);
    endfunction

    function automatic logic [7:0] div_limit(input logic [1:0] code);
        case (code)
            2'h0:    div_limit = 8'h00;
            2'h1:    div_limit = 8'h01;
            2'h2:    div_limit = 8'h03;
            default: div_limit = 8'h07;
        endcase
    endfunction

    assign mapped       = is_mapped(PADDR);
    assign write_access = PSEL && PENABLE && PWRITE && mapped;
    assign read_access  = PSEL && !PWRITE;
    assign PREADY       = 1'b1;
    assign PSLVERR      = PSEL && PENABLE && !mapped;

    // Register writes and mode machine
    always_comb begin
        source_select_next = source_select_reg;
        keepalive_next     = keepalive_reg;
        divider_next       = divider_reg;
        power_down_next    = power_down_reg;
        coarse_next        = coarse_reg;
        fine_next          = fine_reg;
        mode_next          = mode_reg;
        resume_next        = resume_reg;
        if (write_access) begin
            case (PADDR)
                `OFFSET_SOURCE_CONTROL: begin
                    source_select_next =
                        PWDATA[`FIELD_SOURCE_SELECT];
                    keepalive_next =
                        PWDATA[`FIELD_STOP_KEEPALIVE];
                end
                `OFFSET_DIVIDER_CONTROL: begin
                    // Takes effect at once, no staging register
                    divider_next =
                        PWDATA[`FIELD_DIVIDER_HI:`FIELD_DIVIDER_LO];
                    power_down_next =
                        PWDATA[`FIELD_LOOP_POWER_DOWN];
                end
                `OFFSET_COARSE_TRIM: begin
                    coarse_next = PWDATA[7:0];
                end
                `OFFSET_STATUS_TRIM: begin
                    fine_next = PWDATA[`FIELD_FINE_ADJUST];
                end
                default: ;
            endcase
        end
        case (mode_reg)
            clock_source_pkg::MODE_STOP: begin
                if (!STOP_REQUEST)
                    mode_next = resume_reg;
            end
            default: begin
                if (STOP_REQUEST) begin
                    resume_next = mode_reg;
                    mode_next   = clock_source_pkg::MODE_STOP;
                end else if (!source_select_next) begin
                    mode_next =
                        clock_source_pkg::MODE_LOOP_ENGAGED;
                end else if (power_down_next) begin
                    mode_next =
                        clock_source_pkg::MODE_BYPASSED_LP;
                end else begin
                    mode_next =
                        clock_source_pkg::MODE_LOOP_BYPASSED;
                end
            end
        endcase
    end

    // Trim survives reset, so it has no reset branch
    always_ff @(posedge REF_CLK) begin
        coarse_reg <= coarse_next;
        fine_reg   <= fine_next;
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            source_select_reg <= 1'b0;
            keepalive_reg     <= 1'b0;
            divider_reg       <= `RESET_DIVIDER_SELECT;
            power_down_reg    <= 1'b0;
            mode_reg          <= clock_source_pkg::MODE_LOOP_ENGAGED;
            resume_reg        <= clock_source_pkg::MODE_LOOP_ENGAGED;
        end else begin
            source_select_reg <= source_select_next;
            keepalive_reg     <= keepalive_next;
            divider_reg       <= divider_next;
            power_down_reg    <= power_down_next;
            mode_reg          <= mode_next;
            resume_reg        <= resume_next;
        end
    end

    // Switch source only on a synchronized select and while both samples low
    always_comb begin
        sync_next = {sync_reg[SYNC_DEPTH-2:0], source_select_reg};
        active_next = active_reg;
        sample_count_next = sample_count_reg;
        if (sync_reg[SYNC_DEPTH-1] != active_reg) begin
            if (!loop_sample_reg && !ref_sample_reg) begin
                active_next = sync_reg[SYNC_DEPTH-1];
                sample_count_next = sample_count_reg + 4'h1;
            end
        end
    end

    // Sampled copies of the analog clocks feed the divider path
    always_ff @(posedge REF_CLK) begin
        loop_sample_reg <= LOOP_CLK;
        ref_sample_reg  <= REFERENCE_CLK;
    end

    // Count source edges, not high samples, so every ratio is exact
    assign src_now  = active_reg ? ref_sample_reg : loop_sample_reg;
    assign src_edge = src_now != src_prev_reg;

    // Bus divider: output toggles at the selected rate, bus clock half of it
    always_comb begin
        div_count_next = div_count_reg;
        out_next = out_reg;
        bus_next = bus_reg;
        src_prev_next = src_now;
        if (mode_reg == clock_source_pkg::MODE_STOP) begin
            out_next = 1'b0;
        end else if (src_edge) begin
            // Divide by one copies the source edge for edge
            if ({5'h00, div_count_reg} >=
                div_limit(divider_reg)) begin
                div_count_next = 3'h0;
                out_next = !out_reg;
                if (!out_reg)
                    bus_next = !bus_reg;
            end else begin
                div_count_next = div_count_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            sync_reg         <= '0;
            active_reg       <= 1'b0;
            sample_count_reg <= 4'h0;
            div_count_reg    <= 3'h0;
            out_reg          <= 1'b0;
            bus_reg          <= 1'b0;
            src_prev_reg     <= 1'b0;
        end else begin
            sync_reg         <= sync_next;
            active_reg       <= active_next;
            sample_count_reg <= sample_count_next;
            div_count_reg    <= div_count_next;
            out_reg          <= out_next;
            bus_reg          <= bus_next;
            src_prev_reg     <= src_prev_next;
        end
    end

    // Read data registered in setup phase; unused bits are zero
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            PRDATA <= 32'h00000000;
        end else if (read_access && !PENABLE) begin
            PRDATA <= 32'h00000000;
            case (PADDR)
                `OFFSET_SOURCE_CONTROL: begin
                    PRDATA[`FIELD_SOURCE_SELECT]  <= source_select_reg;
                    PRDATA[`FIELD_STOP_KEEPALIVE] <= keepalive_reg;
                end
                `OFFSET_DIVIDER_CONTROL: begin
                    PRDATA[`FIELD_DIVIDER_HI:`FIELD_DIVIDER_LO] <= divider_reg;
                    PRDATA[`FIELD_LOOP_POWER_DOWN] <= power_down_reg;
                end
                `OFFSET_COARSE_TRIM: PRDATA[7:0] <= coarse_reg;
                `OFFSET_STATUS_TRIM: begin
                    PRDATA[`FIELD_ACTIVE_SOURCE] <= active_reg;
                    PRDATA[`FIELD_FINE_ADJUST]   <= fine_reg;
                end
                default: ;
            endcase
        end
    end

    // Loop runs in engaged and plain bypassed modes only
    assign LOOP_ENABLE =
        (mode_reg == clock_source_pkg::MODE_LOOP_ENGAGED)
        || (mode_reg == clock_source_pkg::MODE_LOOP_BYPASSED);
    assign REFERENCE_ENABLE = (mode_reg != clock_source_pkg::MODE_STOP)
                           || keepalive_reg;
    assign LOOP_MULTIPLY = 16'(LOOP_MULTIPLIER);
    assign REFERENCE_TRIM = {coarse_reg, fine_reg};
    assign SYSTEM_CLOCK_OUTPUT = out_reg;
    assign BUS_CLOCK = bus_reg;
    assign MODE = mode_reg;

endmodule

// *** tb/clock_source_asserts.sv ***
// Port-level properties of the clock source control block
`timescale 1ns/1ps
module clock_source_asserts (
    // Clock and reset
    input wire logic        REF_CLK,
    input wire logic        RESET,
    // Register bus
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PSLVERR,
    // Mode and clock controls
    input wire logic        STOP_REQUEST,
    input wire logic        LOOP_ENABLE,
    input wire logic [15:0] LOOP_MULTIPLY,
    input wire logic        SYSTEM_CLOCK_OUTPUT,
    input wire logic [2:0]  MODE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    mode_range_a: assert property (MODE <= 3'h3)
        else $error("mode outside the four modes");
    reset_mode_a: assert property ($past(RESET) |-> MODE == 3'h0)
        else $error("mode not engaged after reset");
    loop_power_a: assert property (LOOP_ENABLE == (MODE < 3'h2))
        else $error("loop enable wrong for mode");
    stop_quiet_a: assert property ((MODE == 3'h3) && ($past(MODE) == 3'h3)
        |-> !SYSTEM_CLOCK_OUTPUT)
        else $error("system clock running in stop");
    multiply_a: assert property (LOOP_MULTIPLY == 16'h0200)
        else $error("loop multiplier wrong");
    stop_entry_a: assert property ($rose(STOP_REQUEST)
        |-> ##[1:4] MODE == 3'h3)
        else $error("stop not entered");
    unmapped_err_a: assert property (PSEL && PENABLE && PADDR > 12'h00c
        |-> PSLVERR)
        else $error("no error on unmapped access");
    select_mode_a: assert property (PSEL && PENABLE && PWRITE && PADDR == 12'h000
        && PWDATA[6] && !STOP_REQUEST && MODE != 3'h3
        |=> MODE == 3'h1 || MODE == 3'h2)
        else $error("select write did not bypass loop");
endmodule

// *** tb/analog_core_model.sv ***
// Model of the loop and reference oscillators feeding the block
`timescale 1ns/1ps
module analog_core_model (
    // Timing and enables
    input  wire logic ref_clk,
    input  wire logic loop_en,
    input  wire logic refr_en,
    // Oscillator outputs
    output logic      loop_clk,
    output logic      refr_clk
);
    logic [2:0] phase_reg = 3'h0;
    always @(negedge ref_clk) phase_reg <= phase_reg + 3'h1;
    // Ratio kept small; the real loop runs far above the reference
    assign loop_clk = loop_en & phase_reg[1];
    assign refr_clk = refr_en & phase_reg[2];
endmodule

// *** tb/internal_clock_source_ctrl_tb.sv ***
// Self-checking bench for the clock source control block
`timescale 1ns/1ps
module internal_clock_source_ctrl_tb;
    logic        REF_CLK = 0, RESET = 1, STOP_REQUEST = 0;
    logic        PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, rd;
    logic        PREADY, PSLVERR, LOOP_CLK, REFERENCE_CLK, err;
    logic        LOOP_ENABLE, REFERENCE_ENABLE, SYSTEM_CLOCK_OUTPUT, BUS_CLOCK;
    logic [15:0] LOOP_MULTIPLY;
    logic [8:0]  REFERENCE_TRIM;
    logic [2:0]  MODE;
    int          n_fail = 0, tests_run = 0;
    internal_clock_source_ctrl dut (.REF_CLK, .RESET, .PSEL, .PENABLE,
        .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .LOOP_CLK,
        .REFERENCE_CLK, .STOP_REQUEST, .LOOP_ENABLE, .REFERENCE_ENABLE,
        .LOOP_MULTIPLY, .REFERENCE_TRIM, .SYSTEM_CLOCK_OUTPUT, .BUS_CLOCK,
        .MODE);
    analog_core_model core (.ref_clk(REF_CLK), .loop_en(LOOP_ENABLE),
        .refr_en(REFERENCE_ENABLE), .loop_clk(LOOP_CLK),
        .refr_clk(REFERENCE_CLK));
    initial forever #20 REF_CLK = ~REF_CLK;
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int k;
        @(posedge REF_CLK);
        PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1;
        k = 0;
        do begin @(posedge REF_CLK); k++; end while (PREADY !== 1'b1 && k < 16);
        if (k >= 16) begin n_fail++; complete_run; end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
    endtask
    task automatic rdchk(string nm, logic [11:0] a, logic [31:0] e);
        apb(0, a, 0);
        chk(nm, rd, e);
    endtask
    task automatic wait_mode(logic [2:0] m);
        for (int k = 0; k < 10 && MODE !== m; k++) @(negedge REF_CLK);
        chk("mode", MODE, m);
    endtask
    task automatic poll(logic v);
        int k;
        k = 0;
        do begin apb(0, 12'h00c, 0); k++; end while (rd[2] !== v && k < 20);
        chk("status", rd[2], v);
    endtask
    // Edge counts over 256 cycles; one edge of slack for the switch
    task automatic rate(int es);
        int s, b;
        logic ps, pb;
        s = 0;
        b = 0;
        ps = SYSTEM_CLOCK_OUTPUT;
        pb = BUS_CLOCK;
        repeat (256) begin
            @(negedge REF_CLK);
            s += SYSTEM_CLOCK_OUTPUT & !ps;
            b += BUS_CLOCK & !pb;
            ps = SYSTEM_CLOCK_OUTPUT;
            pb = BUS_CLOCK;
        end
        chk("sysclk", s >= es - 1 && s <= es + 1, 1);
        chk("busclk", b * 2 >= es - 2 && b * 2 <= es + 2, 1);
    endtask
    task t_reset;
        wait_mode(0);
        rdchk("ctrl1", 12'h000, 32'h0);
        rdchk("ctrl2", 12'h004, 32'h40);
        apb(0, 12'h010, 32'h0);
        chk("bad_err", err, 1);
        chk("bad_rd", rd, 0);
    endtask
    task t_trim;
        apb(1, 12'h008, 32'hffff_ffa5);
        apb(1, 12'h00c, 32'hffff_ffff);
        rdchk("status", 12'h00c, 32'h1);
        chk("trim", REFERENCE_TRIM, 9'h14b);
        apb(1, 12'h000, 32'hffff_ffff);
        rdchk("ctrl1", 12'h000, 32'h41);
        apb(1, 12'h004, 32'hffff_ffff);
        rdchk("ctrl2", 12'h004, 32'hc8);
        @(posedge REF_CLK) RESET <= 1;
        repeat (2) @(posedge REF_CLK);
        RESET <= 0;
        rdchk("coarse", 12'h008, 32'ha5);
        rdchk("fine", 12'h00c, 32'h1);
        rdchk("ctrl1", 12'h000, 32'h0);
    endtask
    task t_divider;
        for (int c = 0; c < 4; c++) begin
            apb(1, 12'h004, 32'(c) << 6);
            rate(64 >> c);
        end
        apb(1, 12'h004, 32'h40);
    endtask
    task t_source;
        apb(1, 12'h000, 32'h40);
        wait_mode(1);
        chk("loop_on", LOOP_ENABLE, 1);
        poll(1);
        rate(16);
        apb(1, 12'h004, 32'h48);
        wait_mode(2);
        chk("loop_off", LOOP_ENABLE, 0);
        rate(16);
    endtask
    task t_stop;
        @(posedge REF_CLK) STOP_REQUEST <= 1;
        wait_mode(3);
        chk("ref_off", REFERENCE_ENABLE, 0);
        rate(0);
        @(posedge REF_CLK) STOP_REQUEST <= 0;
        wait_mode(2);
        apb(1, 12'h000, 32'h41);
        @(posedge REF_CLK) STOP_REQUEST <= 1;
        wait_mode(3);
        chk("ref_on", REFERENCE_ENABLE, 1);
        @(posedge REF_CLK) STOP_REQUEST <= 0;
        wait_mode(2);
        apb(1, 12'h000, 32'h0);
        wait_mode(0);
        poll(0);
    endtask
    initial begin
        repeat (6) @(posedge REF_CLK);
        RESET <= 0;
        t_reset;
        t_trim;
        t_divider;
        t_source;
        t_stop;
        complete_run;
    end
    initial begin
        #800000;
        n_fail++;
        complete_run;
    end
endmodule
bind internal_clock_source_ctrl clock_source_asserts chk_i (.REF_CLK,
    .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSLVERR,
    .STOP_REQUEST, .LOOP_ENABLE, .LOOP_MULTIPLY, .SYSTEM_CLOCK_OUTPUT, .MODE);
